// ===== bench/urx_rx_format_tb_top.sv
// self-checking bench of the receive format and baud divisor block
`timescale 1ns/1ps
`default_nettype none
module urx_rx_format_tb_top;
  import urx_pkg::*;
  logic        clk, reset_n, wr_en, rd_en, rx_line, rx_busy;
  logic [7:0]  addr, lc;
  logic [31:0] wr_data, rd_data, v;
  int          bad_count, checked, cyc, bclk;
  logic [9:0]  exp_q[$];
  logic [7:0]  ofs[5] = '{URX_OFS_LINE, URX_OFS_DIVI, URX_OFS_DIVF,
                          URX_OFS_CTRL, 8'h40};
  logic [31:0] msk[5] = '{32'hff, 32'hffff, 32'h3f, 32'h1, 32'h0};

  urx_rx_format #(.DEPTH(URX_DEPTH)) i_urx_rx_format (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .rx_line(rx_line), .rx_busy(rx_busy));
  urx_tx_model i_urx_tx_model (.clk(clk), .line(rx_line));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic final_report();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // the run should need about 16000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic pull();
    rd(URX_OFS_DATA, v);
    check(v, {22'h0, exp_q.pop_front()});
  endtask

  task automatic frame(input logic [7:0] d, input logic pbad,
                       input logic s1, input logic s2);
    int         nb;
    logic       pen, two, par;
    logic [7:0] m;
    nb = 5 + int'(lc[URX_LC_WLEN +: 2]);
    m = 8'hff >> (8 - nb);
    pen = lc[URX_LC_PEN];
    two = lc[URX_LC_STP2];
    if (lc[URX_LC_SPS]) par = ~lc[URX_LC_EPS];
    else par = ^(d & m) ^ ~lc[URX_LC_EPS];
    i_urx_tx_model.send(d, nb, pen, par ^ pbad, s1, two, s2, bclk);
    exp_q.push_back({pen & pbad, ~s1 | (two & ~s2), d & m});
    repeat (4) @(posedge clk);
  endtask

  initial begin
    reset_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 32'h0;
    bclk = 16;
    void'($urandom(22));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    foreach (ofs[i]) begin
      rd(ofs[i], v);
      check(v, 32'h0);
      wr(ofs[i], 32'hffffffff);
      rd(ofs[i], v);
      check(v, msk[i]);
    end
    wr(URX_OFS_CTRL, 32'h0);
    wr(URX_OFS_DIVF, 32'h0);
    wr(URX_OFS_DIVI, 32'h1);
    // modes: off, odd, even, stick odd, stick even
    for (int w = 0; w < 4; w++) begin
      for (int p = 0; p < 5; p++) begin
        lc = {1'(p > 2), 2'(w), 1'(p[1]), 1'(p[0]),
              1'(p == 2 || p == 4), 1'(p != 0), 1'b0};
        wr(URX_OFS_LINE, {24'h0, lc});
        frame(8'($urandom), 1'b0, 1'b1, 1'b1);
        pull();
        frame(8'($urandom), 1'b1, 1'b1, 1'b1);
        pull();
        frame(8'($urandom), 1'b0, 1'b0, 1'b1);
        pull();
        frame(8'($urandom), 1'b0, 1'b1, 1'b0);
        pull();
      end
    end
    // half-sample fraction stretches every bit to 24 clocks
    wr(URX_OFS_DIVF, 32'h20);
    bclk = 24;
    frame(8'($urandom), 1'b0, 1'b1, 1'b1);
    pull();
    wr(URX_OFS_DIVF, 32'h0);
    // eight samples a bit; divisor rewritten in mid-frame
    lc = 8'h60;
    wr(URX_OFS_LINE, {24'h0, lc});
    wr(URX_OFS_CTRL, 32'h1);
    wr(URX_OFS_DIVI, 32'h3);
    bclk = 24;
    fork
      frame(8'($urandom), 1'b0, 1'b1, 1'b1);
      begin
        repeat (60) @(posedge clk);
        #1;
        check({31'h0, rx_busy}, 32'h1);
        wr(URX_OFS_DIVI, 32'h1);
      end
    join
    pull();
    bclk = 8;
    frame(8'($urandom), 1'b0, 1'b1, 1'b1);
    pull();
    check({31'h0, rx_busy}, 32'h0);
    // character mode holds one word, the second is lost
    frame(8'($urandom), 1'b0, 1'b1, 1'b1);
    frame(8'($urandom), 1'b0, 1'b1, 1'b1);
    void'(exp_q.pop_back());
    rd(URX_OFS_STAT, v);
    check(v, 32'h6);
    pull();
    wr(URX_OFS_STAT, 32'h4);
    rd(URX_OFS_STAT, v);
    check(v, 32'h1);
    // fifo filled past its depth while software stalls, then drained
    lc = 8'h70;
    wr(URX_OFS_LINE, {24'h0, lc});
    repeat (URX_DEPTH) frame(8'($urandom), 1'b0, 1'b1, 1'b1);
    rd(URX_OFS_STAT, v);
    check(v, 32'h2);
    frame(8'($urandom), 1'b0, 1'b1, 1'b1);
    void'(exp_q.pop_back());
    rd(URX_OFS_STAT, v);
    check(v, 32'h6);
    repeat (URX_DEPTH) pull();
    rd(URX_OFS_STAT, v);
    check(v, 32'h5);
    rd(URX_OFS_DATA, v);
    check(v, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire

// ===== bench/urx_tx_model.sv
// behavioural remote transmitter that drives the serial receive line
`timescale 1ns/1ps
`default_nettype none
module urx_tx_model (
  input  wire logic clk,
  output var  logic line
);
  initial line = 1'b1;
  // bclk is the bit period in clocks, set by the bench from the divisor
  task automatic send(input logic [7:0] d, input int nb, input logic pen,
                      input logic pbit, input logic s1, input logic two,
                      input logic s2, input int bclk);
    logic q[$];
    int   n;
    q.push_back(1'b0);
    for (int i = 0; i < nb; i++) begin
      q.push_back(d[i]);
    end
    if (pen) begin
      q.push_back(pbit);
    end
    q.push_back(s1);
    if (two) begin
      q.push_back(s2);
    end
    foreach (q[i]) begin
      n = bclk;
      // a low final stop is cut short so it cannot pass for a new start
      if (i == q.size() - 1 && !q[i]) begin
        n = bclk * 3 / 4;
      end
      repeat (n) @(posedge clk) line <= q[i];
    end
    @(posedge clk) line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== hdl/urx_fifo.sv
// first-in first-out buffer of received characters
`timescale 1ns/1ps
`default_nettype none
module urx_fifo #(
  parameter int W = 10,
  parameter int D = 16
) (
  input  wire logic clk,
  input  wire logic reset_n,
  urx_fifo_if.fifo  f
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] DCNT = (AW+1)'(D);
  if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
    $error("fifo depth must be a power of two of at least 2");
  end
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } urx_fifo_st_t;
  urx_fifo_st_t q;
  urx_fifo_st_t n;
  logic         wr;
  logic         rd;
  always_comb begin
    n  = q;
    wr = f.push_valid && f.push_ready;
    rd = f.pop_valid && f.pop_ready;
    if (wr) begin
      n.wp = q.wp + 1'b1;
    end
    if (rd) begin
      n.rp = q.rp + 1'b1;
    end
    if (wr && !rd) begin
      n.cnt = q.cnt + 1'b1;
    end else if (rd && !wr) begin
      n.cnt = q.cnt - 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign f.push_ready = (q.cnt != DCNT);
  assign f.pop_valid  = (q.cnt != '0);
  // read address is the next-cycle read pointer so the head word is always ready
  urx_mem #(.W(W), .D(D)) u_mem (
    .clk     (clk),
    .reset_n (reset_n),
    .we      (wr),
    .waddr   (q.wp),
    .wdata   (f.push_data),
    .raddr   (n.rp),
    .rdata   (f.pop_data)
  );
endmodule
`default_nettype wire

// ===== hdl/urx_mem.sv
// small register-file memory with registered, write-through read data
`timescale 1ns/1ps
`default_nettype none
module urx_mem #(
  parameter int W = 10,
  parameter int D = 16
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 we,
  input  wire logic [$clog2(D)-1:0] waddr,
  input  wire logic [W-1:0]         wdata,
  input  wire logic [$clog2(D)-1:0] raddr,
  output var  logic [W-1:0]         rdata
);
  if (W < 1 || D < 2) begin : g_chk
    $error("memory needs a width of at least 1 and a depth of at least 2");
  end
  typedef struct packed {
    logic [D-1:0][W-1:0] m;
    logic [W-1:0]        q;
  } urx_mem_st_t;
  urx_mem_st_t s;
  urx_mem_st_t n;
  always_comb begin
    n = s;
    if (we) begin
      n.m[waddr] = wdata;
    end
    // bypass so a word written into an empty slot shows next cycle
    n.q = (we && waddr == raddr) ? wdata : s.m[raddr];
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign rdata = s.q;
endmodule
`default_nettype wire

// ===== hdl/urx_rx_format.sv
// serial receiver with programmable frame format and baud divisor
// Operation
// RULE1: parity is checked only when parity enable is set; polarity matters then.
// RULE2: odd polarity accepts an odd count of ones in data and parity.
// RULE3: even polarity accepts an even count of ones in data and parity.
// RULE4: two-stop select clear expects one stop bit, set checks two.
// RULE5: FIFO enable clear gives a single holding stage, set uses the FIFO.
// RULE6: word length field selects five to eight data bits.
// RULE7: stick parity expects constant parity: zero for even, one for odd.
// RULE8: oversample select clear divides each bit into sixteen samples.
// RULE9: oversample select set divides each bit into eight samples.
// RULE10: integer divisor is sixteen bits in the integer divisor register.
// RULE11: new divisor values apply only after the current character ends.
// RULE12: fractional divisor is six bits, zero after reset.
// RULE13: low stop bit flags framing error; parity mismatch flags parity error.
`timescale 1ns/1ps
`default_nettype none
module urx_rx_format #(
  parameter int DEPTH = urx_pkg::URX_DEPTH
) (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic [urx_pkg::URX_AW-1:0] addr,
  input  wire logic [31:0]               wr_data,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  output var  logic [31:0]               rd_data,
  input  wire logic                      rx_line,
  output var  logic                      rx_busy
);
  import urx_pkg::*;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("receive fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [7:0]            lc;
    logic [URX_DIVI_W-1:0] divi;
    logic [URX_DIVF_W-1:0] divf;
    logic                  osel;
    logic                  ovr;
    logic [URX_DIVI_W-1:0] a_divi;
    logic [URX_DIVF_W-1:0] a_divf;
    logic                  a_os;
    logic [7:0]            fm;
    logic [1:0]            sync;
    urx_state_t            st;
    logic [URX_DIVI_W-1:0] bcnt;
    logic [URX_DIVF_W-1:0] acc;
    logic [3:0]            sc;
    logic [2:0]            bi;
    logic [URX_DATA_W-1:0] sh;
    logic                  pbit;
    logic                  ferr;
    logic                  pv;
    logic [URX_WORD_W-1:0] pd;
    logic [31:0]           rdq;
    logic                  busy;
  } urx_top_st_t;

  urx_top_st_t           q;
  urx_top_st_t           n;
  logic                  line;
  logic                  tick;
  logic                  samp;
  logic                  fin;
  logic                  push_ok;
  logic                  pop;
  logic [3:0]            om;
  logic [2:0]            lmax;
  logic [URX_DIVF_W:0]   fsum;

  urx_fifo_if #(.W(URX_WORD_W)) fq ();

  urx_fifo #(.W(URX_WORD_W), .D(DEPTH)) u_fifo (
    .clk     (clk),
    .reset_n (reset_n),
    .f       (fq.fifo)
  );

  // parity error of a finished character under the latched format
  function automatic logic par_err(input logic [7:0] fm,
                                   input logic [7:0] d,
                                   input logic       p);
    logic x;
    x = ^{d, p};
    if (!fm[URX_LC_PEN]) begin
      par_err = 1'b0; // RULE1
    end else if (fm[URX_LC_SPS]) begin
      par_err = (p != ~fm[URX_LC_EPS]); // RULE7
    end else if (fm[URX_LC_EPS]) begin
      par_err = x; // RULE3
    end else begin
      par_err = ~x; // RULE2
    end
  endfunction

  function automatic logic [3:0] osr_max(input logic os);
    osr_max = os ? URX_OSR8_MAX : URX_OSR16_MAX; // RULE8 RULE9
  endfunction

  always_comb begin
    n      = q;
    fin    = 1'b0;
    n.pv   = 1'b0;
    n.sync = {q.sync[0], rx_line};
    line   = q.sync[1];
    om     = osr_max(q.a_os);
    lmax   = {1'b1, q.fm[URX_LC_WLEN+1:URX_LC_WLEN]}; // RULE6
    tick   = (q.st != URX_IDLE) && (q.bcnt == '0);
    samp   = tick && (q.sc == om);
    fsum   = {1'b0, q.acc} + {1'b0, q.a_divf};
    // fractional carry stretches one sample period by a cycle
    if (q.st != URX_IDLE) begin
      if (tick) begin
        n.acc  = fsum[URX_DIVF_W-1:0]; // RULE12
        n.bcnt = q.a_divi - 16'h0001 + {15'h0000, fsum[URX_DIVF_W]};
        n.sc   = samp ? 4'h0 : q.sc + 4'h1;
      end else begin
        n.bcnt = q.bcnt - 16'h0001;
      end
    end
    case (q.st)
      URX_IDLE: begin
        // divisor and format are captured here and frozen for the frame
        if (!line && q.divi != '0) begin
          n.st     = URX_START;
          n.a_divi = q.divi; // RULE11
          n.a_divf = q.divf; // RULE11
          n.a_os   = q.osel;
          n.fm     = q.lc;
          n.bcnt   = q.divi - 16'h0001;
          n.acc    = '0;
          n.sc     = 4'h0;
          n.bi     = 3'h0;
          n.sh     = '0;
          n.pbit   = 1'b0;
          n.ferr   = 1'b0;
        end
      end
      URX_START: begin
        // mid-start check rejects glitches shorter than half a bit
        if (tick && q.sc == (om >> 1)) begin
          n.sc = 4'h0;
          n.st = line ? URX_IDLE : URX_DATA;
        end
      end
      URX_DATA: begin
        if (samp) begin
          n.sh[q.bi] = line;
          if (q.bi == lmax) begin // RULE6
            n.st = q.fm[URX_LC_PEN] ? URX_PAR : URX_STOP1; // RULE1
          end else begin
            n.bi = q.bi + 3'h1;
          end
        end
      end
      URX_PAR: begin
        if (samp) begin
          n.pbit = line;
          n.st   = URX_STOP1;
        end
      end
      URX_STOP1: begin
        if (samp) begin
          n.ferr = !line; // RULE13
          if (q.fm[URX_LC_STP2]) begin
            n.st = URX_STOP2; // RULE4
          end else begin
            fin = 1'b1;
          end
        end
      end
      URX_STOP2: begin
        if (samp) begin
          n.ferr = q.ferr | !line; // RULE13
          fin    = 1'b1;
        end
      end
      default: begin
        n.st = URX_IDLE;
      end
    endcase
    if (fin) begin
      n.st = URX_IDLE;
      n.pv = 1'b1;
      n.pd = {par_err(q.fm, q.sh, q.pbit), n.ferr, q.sh}; // RULE13
    end
    // character mode takes a new word only into an empty stage
    push_ok = q.pv && fq.push_ready
              && (q.fm[URX_LC_FEN] || !fq.pop_valid); // RULE5
    pop = rd_en && (addr == URX_OFS_DATA);
    if (wr_en) begin
      if (addr == URX_OFS_LINE) begin
        n.lc = wr_data[7:0];
      end else if (addr == URX_OFS_DIVI) begin
        n.divi = wr_data[URX_DIVI_W-1:0]; // RULE10
      end else if (addr == URX_OFS_DIVF) begin
        n.divf = wr_data[URX_DIVF_W-1:0]; // RULE12
      end else if (addr == URX_OFS_CTRL) begin
        n.osel = wr_data[URX_CT_OVS];
      end else if (addr == URX_OFS_STAT) begin
        if (wr_data[URX_ST_OVR]) begin
          n.ovr = 1'b0;
        end
      end
    end
    // a lost character sets overrun even against a clear in the same cycle
    if (q.pv && !push_ok) begin
      n.ovr = 1'b1;
    end
    n.rdq = 32'h0000_0000;
    if (rd_en) begin
      if (addr == URX_OFS_LINE) begin
        n.rdq = {24'h00_0000, q.lc};
      end else if (addr == URX_OFS_DIVI) begin
        n.rdq = {16'h0000, q.divi};
      end else if (addr == URX_OFS_DIVF) begin
        n.rdq = {26'h000_0000, q.divf};
      end else if (addr == URX_OFS_CTRL) begin
        n.rdq = {31'h0000_0000, q.osel};
      end else if (addr == URX_OFS_DATA) begin
        if (fq.pop_valid) begin
          n.rdq = {22'h00_0000, fq.pop_data};
        end
      end else if (addr == URX_OFS_STAT) begin
        // character mode shows its single stage full once it holds a word
        n.rdq = {28'h000_0000, q.busy, q.ovr,
                 !fq.push_ready
                 || (!q.fm[URX_LC_FEN] && fq.pop_valid), // RULE5
                 !fq.pop_valid};
      end
    end
    n.busy = (n.st != URX_IDLE);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q      <= '0;
      q.lc   <= URX_LC_RST;
      q.divi <= URX_DIVI_RST;
      q.divf <= URX_DIVF_RST; // RULE12
      q.osel <= URX_OVS_RST;
    end else begin
      q <= n;
    end
  end

  assign fq.push_valid = q.pv && (q.fm[URX_LC_FEN] || !fq.pop_valid);
  assign fq.push_data  = q.pd;
  assign fq.pop_ready  = pop;
  assign rd_data       = q.rdq;
  assign rx_busy       = q.busy;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  par_off_a: assert property ( // RULE1
    q.pv && !q.fm[URX_LC_PEN] |-> !q.pd[URX_DW_PERR])
    else $error("parity error flagged with parity disabled");

  par_odd_a: assert property ( // RULE2
    q.pv && q.fm[URX_LC_PEN] && !q.fm[URX_LC_SPS] && !q.fm[URX_LC_EPS]
    |-> q.pd[URX_DW_PERR] == ~(^{q.pd[7:0], q.pbit}))
    else $error("odd parity check wrong");

  par_even_a: assert property ( // RULE3
    q.pv && q.fm[URX_LC_PEN] && !q.fm[URX_LC_SPS] && q.fm[URX_LC_EPS]
    |-> q.pd[URX_DW_PERR] == (^{q.pd[7:0], q.pbit}))
    else $error("even parity check wrong");

  two_stop_a: assert property ( // RULE4
    q.st == URX_STOP2 |-> q.fm[URX_LC_STP2])
    else $error("second stop bit checked with one stop selected");

  one_stop_a: assert property ( // RULE4
    q.st == URX_STOP1 && samp && !q.fm[URX_LC_STP2] |=> q.pv)
    else $error("one-stop frame did not finish at first stop");

  char_mode_a: assert property ( // RULE5
    q.pv && !q.fm[URX_LC_FEN] && fq.pop_valid |=> q.ovr)
    else $error("character mode accepted into a full stage");

  word_len_a: assert property ( // RULE6
    q.pv && q.fm[URX_LC_WLEN+1:URX_LC_WLEN] == 2'b00
    |-> q.pd[7:5] == 3'h0)
    else $error("five-bit word carries extra bits");

  par_stick_a: assert property ( // RULE7
    q.pv && q.fm[URX_LC_PEN] && q.fm[URX_LC_SPS]
    |-> q.pd[URX_DW_PERR] == (q.pbit == q.fm[URX_LC_EPS]))
    else $error("stick parity check wrong");

  osr_span_a: assert property ( // RULE8 RULE9
    q.st != URX_IDLE |-> q.sc <= (q.a_os ? URX_OSR8_MAX : URX_OSR16_MAX))
    else $error("sample index beyond oversampling ratio");

  divi_wr_a: assert property ( // RULE10
    wr_en && addr == URX_OFS_DIVI
    |=> q.divi == $past(wr_data[URX_DIVI_W-1:0]))
    else $error("integer divisor not stored");

  div_hold_a: assert property ( // RULE11
    q.busy && $past(q.busy)
    |-> $stable(q.a_divi) && $stable(q.a_divf) && $stable(q.a_os))
    else $error("divisor changed inside a character");

  divf_rd_a: assert property ( // RULE12
    rd_en && addr == URX_OFS_DIVF
    |=> rd_data == {26'h000_0000, $past(q.divf)})
    else $error("fraction register read back wrong");

  frame_err_a: assert property ( // RULE13
    q.st == URX_STOP1 && samp && !line && !q.fm[URX_LC_STP2]
    |=> q.pv && q.pd[URX_DW_FERR])
    else $error("low stop bit not flagged");

  stop2_err_a: assert property ( // RULE13
    q.st == URX_STOP2 && samp && !line
    |=> q.pv && q.pd[URX_DW_FERR])
    else $error("low second stop bit not flagged");

  fifo_push_a: assert property ( // RULE5
    q.pv && q.fm[URX_LC_FEN] && fq.push_ready |-> fq.push_valid)
    else $error("fifo mode refused a character with room");

  div_load_a: assert property ( // RULE11
    $rose(q.busy)
    |-> q.a_divi == $past(q.divi) && q.a_divf == $past(q.divf))
    else $error("divisor not taken at frame start");

  full_stat_a: assert property ( // RULE5
    rd_en && addr == URX_OFS_STAT && !q.fm[URX_LC_FEN] && fq.pop_valid
    |=> rd_data[URX_ST_FULL])
    else $error("held character not shown as full");

  clean_char_c: cover property (q.pv && q.pd[9:8] == 2'b00);
  par_fail_c:   cover property (q.pv && q.pd[URX_DW_PERR]);
  two_stop_c:   cover property (q.st == URX_STOP2 && samp);
  overrun_c:    cover property (q.pv && !push_ok);
  mid_div_c:    cover property (q.busy && wr_en && addr == URX_OFS_DIVI);
endmodule
`default_nettype wire

// ===== shared/urx_fifo_if.sv
// handshake bundle between the receiver and its character FIFO
`timescale 1ns/1ps
`default_nettype none
interface urx_fifo_if #(parameter int W = 10);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  modport src  (output push_valid, push_data, pop_ready,
                input  push_ready, pop_valid, pop_data);
  modport fifo (input  push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// ===== shared/urx_pkg.sv
// shared constants and types of the receive format and baud divisor block
package urx_pkg;
  localparam int URX_AW     = 8;
  localparam int URX_DIVI_W = 16;
  localparam int URX_DIVF_W = 6;
  localparam int URX_DATA_W = 8;
  localparam int URX_WORD_W = 10;
  localparam int URX_DEPTH  = 16;
  // register byte offsets
  localparam logic [7:0] URX_OFS_LINE = 8'h1c;
  localparam logic [7:0] URX_OFS_DIVI = 8'h24;
  localparam logic [7:0] URX_OFS_DIVF = 8'h28;
  localparam logic [7:0] URX_OFS_CTRL = 8'h30;
  localparam logic [7:0] URX_OFS_DATA = 8'h34;
  localparam logic [7:0] URX_OFS_STAT = 8'h38;
  // line control field positions
  localparam int URX_LC_PEN  = 1;
  localparam int URX_LC_EPS  = 2;
  localparam int URX_LC_STP2 = 3;
  localparam int URX_LC_FEN  = 4;
  localparam int URX_LC_WLEN = 5;
  localparam int URX_LC_SPS  = 7;
  // control, status and data word field positions
  localparam int URX_CT_OVS   = 0;
  localparam int URX_ST_EMPTY = 0;
  localparam int URX_ST_FULL  = 1;
  localparam int URX_ST_OVR   = 2;
  localparam int URX_ST_BUSY  = 3;
  localparam int URX_DW_FERR  = 8;
  localparam int URX_DW_PERR  = 9;
  // values after reset
  localparam logic [7:0]  URX_LC_RST   = 8'h00;
  localparam logic [15:0] URX_DIVI_RST = 16'h0000;
  localparam logic [5:0]  URX_DIVF_RST = 6'h00;
  localparam logic        URX_OVS_RST  = 1'b0;
  // last sample index of a bit period for 16x and 8x oversampling
  localparam logic [3:0]  URX_OSR16_MAX = 4'hf;
  localparam logic [3:0]  URX_OSR8_MAX  = 4'h7;
  typedef enum logic [2:0] {
    URX_IDLE  = 3'b000,
    URX_START = 3'b001,
    URX_DATA  = 3'b010,
    URX_PAR   = 3'b011,
    URX_STOP1 = 3'b100,
    URX_STOP2 = 3'b101
  } urx_state_t;
endpackage
